// [hw/wsq_cfg.svh]
`ifndef WSQ_CFG_SVH
`define WSQ_CFG_SVH
// Clock and step pacing
`define WSQ_CLK_NS        8
`define WSQ_STEP_NS       40
`define WSQ_STEP_SLOW_NS  400
`define WSQ_STEP_CYC      ((`WSQ_STEP_NS + `WSQ_CLK_NS - 1) / `WSQ_CLK_NS)
`define WSQ_STEP_SLOW_CYC \
  ((`WSQ_STEP_SLOW_NS + `WSQ_CLK_NS - 1) / `WSQ_CLK_NS)
// Register offsets
`define WSQ_DIRECT_ADDR   16'h0016
`define WSQ_SPARE_ADDR    16'h0042
`define WSQ_STATUS_ADDR   16'h0020
`define WSQ_EVT_IDX_BASE  16'h0070
`define WSQ_TRG_IDX_TBL {16'h006b, 16'h006a, 16'h0069, 16'h0068, \
  16'h005e, 16'h005d, 16'h005c, 16'h005b, 16'h005a, 16'h0059, \
  16'h0050, 16'h004f, 16'h004e, 16'h004d, 16'h004c, 16'h004b}
`define WSQ_MEM_BASE      16'h3000
`define WSQ_MEM_LAST      16'h31f6
// Direct control fields and reset values
`define WSQ_ABORT_BIT     11
`define WSQ_GO_BIT        10
`define WSQ_EN_BIT        9
`define WSQ_DIR_IDX_RST   9'h000
`define WSQ_IDX_RST       9'h1ff
`define WSQ_ABORT_IDX     9'h1ff
`define WSQ_LAST_ENTRY    9'h0fb
`define WSQ_ENTRIES       252
// Command entry layout
`define WSQ_ENT_LAST_BIT  0
`define WSQ_ENT_ADDR_LSB  2
`define WSQ_ENT_ADDR_MSB  15
`define WSQ_ENT_DATA_LSB  16
// Built-in path sequences, earpiece in the upper half
`define WSQ_PATH_UP_IDX   {9'h0e0, 9'h0f0}
`define WSQ_PATH_DN_IDX   {9'h0e8, 9'h0f8}
// Request sources and queue
`define WSQ_SRC_N         25
`define WSQ_SRC_DIRECT    5'h18
`define WSQ_Q_DEPTH       32
`define WSQ_Q_AW          5
`define WSQ_Q_FULL        6'h20
`endif

// [hw/wsq_pkg.sv]
`include "wsq_cfg.svh"
package wsq_pkg;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_FETCH = 4'h2,
    S_EXEC  = 4'h4,
    S_GAP   = 4'h8
  } wsq_state_t;

  typedef struct packed {
    logic       direct;
    logic [8:0] idx;
  } wsq_qent_t;

  typedef struct packed {
    wsq_state_t                 st;
    logic [8:0]                 ptr;
    logic                       direct;
    logic [7:0]                 gap;
    logic [`WSQ_SRC_N-1:0]      pend;
    logic                       en;
    logic                       go;
    logic [8:0]                 dirIdx;
    logic [15:0][8:0]           trgIdx;
    logic [3:0][8:0]            evtIdx;
    logic [1:0]                 pathLvl;
    logic                       wrEn;
    logic [13:0]                wrAddr;
    logic [15:0]                wrData;
    logic                       rdValid;
    logic [31:0]                rdData;
  } wsq_top_st_t;

  typedef struct packed {
    wsq_qent_t [`WSQ_Q_DEPTH-1:0] ent;
    logic [`WSQ_Q_AW-1:0]         wp;
    logic [`WSQ_Q_AW-1:0]         rp;
    logic [`WSQ_Q_AW:0]           cnt;
  } wsq_q_st_t;

  typedef struct packed {
    logic [`WSQ_ENTRIES-1:0][31:0] mem;
    logic [31:0]                   rdA;
  } wsq_mem_st_t;
endpackage

// [hw/wsq_q_if.sv]
`timescale 1ns/1ns
interface wsq_q_if;
  logic              pushValid;
  logic              pushReady;
  wsq_pkg::wsq_qent_t pushData;
  logic              popValid;
  logic              popReady;
  wsq_pkg::wsq_qent_t popData;
  modport src  (output pushValid, pushData, popReady,
                input  pushReady, popValid, popData);
  modport fifo (input  pushValid, pushData, popReady,
                output pushReady, popValid, popData);
endinterface

// [hw/wsq_queue.sv]
`timescale 1ns/1ns
`include "wsq_cfg.svh"
module wsq_queue (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic flush,
  wsq_q_if.fifo    q
);
  wsq_pkg::wsq_q_st_t st_ff;
  wsq_pkg::wsq_q_st_t nxt_st;
  logic               doPush;
  logic               doPop;

  // Full stalls the pending serializer, so requests wait rather than drop
  assign q.pushReady = (st_ff.cnt != `WSQ_Q_FULL);
  assign q.popValid  = (st_ff.cnt != '0);
  assign q.popData   = st_ff.ent[st_ff.rp];

  // Arrival order is kept by a plain ring buffer
  always_comb begin
    nxt_st = st_ff;
    doPush = q.pushValid && q.pushReady;
    doPop  = q.popValid && q.popReady;
    if (doPush) begin
      nxt_st.ent[st_ff.wp] = q.pushData;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (doPop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + {5'h0, doPush} - {5'h0, doPop};
    if (flush) begin
      nxt_st.wp  = '0;
      nxt_st.rp  = '0;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// [hw/wsq_mem.sv]
`timescale 1ns/1ns
`include "wsq_cfg.svh"
module wsq_mem (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrIdx,
  input  wire logic [31:0] wrData,
  input  wire logic [7:0]  rdIdxA,
  output logic      [31:0] rdDataA,
  input  wire logic [7:0]  rdIdxB,
  output logic      [31:0] rdDataB
);
  wsq_pkg::wsq_mem_st_t st_ff;
  wsq_pkg::wsq_mem_st_t nxt_st;

  assign rdDataA = st_ff.rdA;
  // Host readback is combinational; the top registers it
  assign rdDataB = ({1'b0, rdIdxB} <= `WSQ_LAST_ENTRY) ?
                   st_ff.mem[rdIdxB] : 32'h0;

  // Engine port is registered: data follows the index by one cycle
  always_comb begin
    nxt_st = st_ff;
    if (wrEn && ({1'b0, wrIdx} <= `WSQ_LAST_ENTRY)) begin
      nxt_st.mem[wrIdx] = wrData;
    end
    nxt_st.rdA = ({1'b0, rdIdxA} <= `WSQ_LAST_ENTRY) ?
                 st_ff.mem[rdIdxA] : 32'h0;
  end

  // No soft reset input here, so contents survive it
  always_ff @(posedge sys_clk or negedge rstn) begin // R03
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// [hw/wsq_top.sv]
`timescale 1ns/1ns
`include "wsq_cfg.svh"
// Contract
// R01: Sixteen trigger bits each start their sequence
// R02: Start index 0x1ff aborts, no writes
// R03: Command memory survives soft reset only
// R04: Host reprograms sequences after hard resets
// R05: Enable bit 9 gates direct start only
// R06: Go bit 10 self-clears at sequence end
// R07: Direct start while busy waits pending
// R08: Host waits on busy after direct start
// R09: Requests queue while sequencer occupied
// R10: Abort bit 11 stops current sequence only
// R11: 252 commands mapped at 0x3000-0x31f6
// R12: Direct index bits 8:0, reset zero
// R13: Trigger sixteen is spare bit 15
// R14: Runs without system clock, coarser steps
// R15: Output path changes schedule built-in sequences
// R16: Internal events schedule host-indexed sequences
// R17: Served in arrival order, one at a time
// R18: Busy while anything queued or running
module wsq_top (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        swReset,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        systemClockPresent,
  input  wire logic [3:0]  autoEvent,
  input  wire logic [1:0]  outPathEnable,
  output logic             regRdValid,
  output logic      [31:0] regRdData,
  output logic             seqWrEn,
  output logic      [13:0] seqWrAddr,
  output logic      [15:0] seqWrData,
  output logic             sequencerOccupiedFlag
);
  localparam logic [255:0] TrgIdxTbl = `WSQ_TRG_IDX_TBL;
  localparam logic [17:0]  PathUpTbl = `WSQ_PATH_UP_IDX;
  localparam logic [17:0]  PathDnTbl = `WSQ_PATH_DN_IDX;
  localparam logic [7:0]   StepFast  = 8'(`WSQ_STEP_CYC);
  localparam logic [7:0]   StepSlow  = 8'(`WSQ_STEP_SLOW_CYC);
  localparam int           GapMax    = 60;
  localparam wsq_pkg::wsq_top_st_t RstSt = '{
    st:     wsq_pkg::S_IDLE,
    dirIdx: `WSQ_DIR_IDX_RST,
    trgIdx: {16{`WSQ_IDX_RST}},
    evtIdx: {4{`WSQ_IDX_RST}},
    default: '0
  };

  wsq_pkg::wsq_top_st_t         st_ff;
  wsq_pkg::wsq_top_st_t         nxt_st;
  logic [15:0]                  trgAddrHit;
  logic [3:0]                   evtAddrHit;
  logic [`WSQ_SRC_N-1:0][8:0]   srcIdx;
  logic [`WSQ_SRC_N-1:0]        newReq;
  logic [1:0]                   pathRise;
  logic [1:0]                   pathFall;
  logic [15:0]                  memOff;
  logic                         memHit;
  logic [31:0]                  memRdA;
  logic [31:0]                  memRdB;
  logic                         dirWr;
  logic                         spareWr;
  logic                         abortNow;
  logic                         lastEnt;
  logic                         dirDone;
  logic                         goSet;
  logic [4:0]                   sel;

  wsq_q_if qIf ();

  // Per-trigger index decode and source index table
  for (genvar g = 0; g < 16; g++) begin : gTrg
    assign trgAddrHit[g] = (regAddr == TrgIdxTbl[g*16 +: 16]);
    assign srcIdx[g]     = st_ff.trgIdx[g];
    if (g < 4) begin : gEvt
      assign evtAddrHit[g] = (regAddr == `WSQ_EVT_IDX_BASE + 16'(g));
    end
  end
  assign srcIdx[19:16] = st_ff.evtIdx;
  assign srcIdx[21:20] = PathUpTbl;
  assign srcIdx[23:22] = PathDnTbl;
  assign srcIdx[24]    = st_ff.dirIdx;

  // Command window: two addresses per 32-bit entry, even ones only
  assign memOff = regAddr - `WSQ_MEM_BASE;
  assign memHit = (regAddr >= `WSQ_MEM_BASE) && // R11
                  (regAddr <= `WSQ_MEM_LAST) && !regAddr[0];

  wsq_mem wsq_mem_i (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wrEn    (regWrEn && memHit),
    .wrIdx   (memOff[8:1]),
    .wrData  (regWrData),
    .rdIdxA  (st_ff.ptr[7:0]),
    .rdDataA (memRdA),
    .rdIdxB  (memOff[8:1]),
    .rdDataB (memRdB)
  );
  wsq_queue wsq_queue_i (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .flush   (swReset),
    .q       (qIf.fifo)
  );
  // Pending bits drain into the queue one per cycle, lowest source first
  assign qIf.pushValid = |st_ff.pend;
  assign qIf.pushData  = '{direct: (sel == `WSQ_SRC_DIRECT),
                           idx:    srcIdx[sel]};
  assign qIf.popReady  = (st_ff.st == wsq_pkg::S_IDLE);

  assign dirWr    = regWrEn && (regAddr == `WSQ_DIRECT_ADDR);
  assign spareWr  = regWrEn && (regAddr == `WSQ_SPARE_ADDR);
  assign abortNow = dirWr && regWrData[`WSQ_ABORT_BIT] &&
                    (st_ff.st != wsq_pkg::S_IDLE);
  assign lastEnt  = memRdA[`WSQ_ENT_LAST_BIT] ||
                    (st_ff.ptr == `WSQ_LAST_ENTRY);
  assign pathRise = outPathEnable & ~st_ff.pathLvl;
  assign pathFall = ~outPathEnable & st_ff.pathLvl;
  // Outputs straight from state flops
  assign seqWrEn   = st_ff.wrEn;
  assign seqWrAddr = st_ff.wrAddr;
  assign seqWrData = st_ff.wrData;
  assign regRdValid = st_ff.rdValid;
  assign regRdData  = st_ff.rdData;
  // Last write pulse counts as busy so pollers never see a gap
  assign sequencerOccupiedFlag = (st_ff.st != wsq_pkg::S_IDLE) || // R18
                                 qIf.popValid || (|st_ff.pend) || st_ff.wrEn;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wrEn = 1'b0;
    dirDone = 1'b0;
    sel = 5'h0;
    for (int k = `WSQ_SRC_N - 1; k >= 0; k--) begin
      if (st_ff.pend[k]) begin
        sel = 5'(k);
      end
    end
    // Sequence engine: fetch, write, pace, repeat
    unique case (st_ff.st)
      wsq_pkg::S_IDLE: begin
        if (qIf.popValid) begin // R17
          nxt_st.direct = qIf.popData.direct;
          nxt_st.ptr    = qIf.popData.idx;
          if (qIf.popData.idx > `WSQ_LAST_ENTRY) begin // R02
            dirDone = qIf.popData.direct;
          end else begin
            nxt_st.st = wsq_pkg::S_FETCH;
          end
        end
      end
      wsq_pkg::S_FETCH: begin
        nxt_st.st = wsq_pkg::S_EXEC;
      end
      wsq_pkg::S_EXEC: begin
        nxt_st.wrEn   = 1'b1;
        nxt_st.wrAddr = memRdA[`WSQ_ENT_ADDR_MSB:`WSQ_ENT_ADDR_LSB];
        nxt_st.wrData = memRdA[31:`WSQ_ENT_DATA_LSB];
        if (lastEnt) begin
          nxt_st.st = wsq_pkg::S_IDLE;
          dirDone = st_ff.direct;
        end else begin
          nxt_st.ptr = st_ff.ptr + 9'h1; // R17
          // Without system clock the step pace falls back to a slow count
          nxt_st.gap = (systemClockPresent ? StepFast : StepSlow) - 8'h1; // R14
          nxt_st.st  = wsq_pkg::S_GAP;
        end
      end
      wsq_pkg::S_GAP: begin
        if (st_ff.gap == 8'h0) begin
          nxt_st.st = wsq_pkg::S_FETCH;
        end else begin
          nxt_st.gap = st_ff.gap - 8'h1;
        end
      end
    endcase
    // Abort kills the running sequence only; the queue is left alone
    if (abortNow) begin // R10
      nxt_st.st   = wsq_pkg::S_IDLE;
      nxt_st.wrEn = 1'b0;
      dirDone = st_ff.direct;
    end
    if (dirDone) begin
      nxt_st.go = 1'b0; // R06
    end
    // Register writes
    if (dirWr) begin
      nxt_st.en     = regWrData[`WSQ_EN_BIT];
      nxt_st.dirIdx = regWrData[8:0]; // R12
    end
    for (int k = 0; k < 16; k++) begin
      if (regWrEn && trgAddrHit[k]) begin
        nxt_st.trgIdx[k] = regWrData[8:0];
      end
    end
    for (int k = 0; k < 4; k++) begin
      if (regWrEn && evtAddrHit[k]) begin
        nxt_st.evtIdx[k] = regWrData[8:0];
      end
    end
    // Direct start needs the enable written alongside; set beats clear
    goSet = dirWr && regWrData[`WSQ_GO_BIT] && // R05
            regWrData[`WSQ_EN_BIT] && (!st_ff.go || dirDone);
    if (goSet) begin
      nxt_st.go = 1'b1; // R07
    end
    newReq = {goSet, pathFall, pathRise, autoEvent, // R15 R16
              spareWr ? regWrData[15:0] : 16'h0}; // R01 R13
    nxt_st.pathLvl = outPathEnable;
    if (qIf.pushValid && qIf.pushReady) begin
      nxt_st.pend[sel] = 1'b0;
    end
    nxt_st.pend = nxt_st.pend | newReq; // R09
    // Registered readback; unmapped addresses read zero
    nxt_st.rdValid = regRdEn;
    nxt_st.rdData  = 32'h0;
    if (regRdEn) begin
      if (regAddr == `WSQ_DIRECT_ADDR) begin
        nxt_st.rdData = {21'h0, st_ff.go, st_ff.en, st_ff.dirIdx};
      end else if (regAddr == `WSQ_STATUS_ADDR) begin
        nxt_st.rdData = {31'h0, sequencerOccupiedFlag};
      end else if (memHit) begin
        nxt_st.rdData = memRdB;
      end
      for (int k = 0; k < 16; k++) begin
        if (trgAddrHit[k]) begin
          nxt_st.rdData = {23'h0, st_ff.trgIdx[k]};
        end
      end
      for (int k = 0; k < 4; k++) begin
        if (evtAddrHit[k]) begin
          nxt_st.rdData = {23'h0, st_ff.evtIdx[k]};
        end
      end
    end
    if (swReset) begin
      nxt_st = RstSt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= RstSt;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn || swReset);
  sequence s_stepOn;
    (st_ff.st == wsq_pkg::S_EXEC) && !lastEnt && !abortNow;
  endsequence
  sequence s_dirDone;
    (st_ff.st == wsq_pkg::S_EXEC) && st_ff.direct && lastEnt && !abortNow;
  endsequence
  property p_abortIndex;
    (st_ff.st == wsq_pkg::S_IDLE) && qIf.popValid &&
    (qIf.popData.idx == `WSQ_ABORT_IDX)
    |=> (st_ff.st == wsq_pkg::S_IDLE) ##1 !seqWrEn;
  endproperty
  a_abortIndex: assert property (p_abortIndex) // R02
    else $error("Abort index started a sequence");
  property p_gateOff;
    dirWr && regWrData[`WSQ_GO_BIT] && !regWrData[`WSQ_EN_BIT] && !st_ff.go
    |=> !st_ff.go && !st_ff.pend[`WSQ_SRC_DIRECT];
  endproperty
  a_gateOff: assert property (p_gateOff) // R05
    else $error("Direct start taken while disabled");
  property p_goClear;
    s_dirDone ##0 !goSet |=> !st_ff.go;
  endproperty
  a_goClear: assert property (p_goClear) // R06
    else $error("Go bit not cleared at sequence end");
  property p_dirPending;
    goSet && (st_ff.st != wsq_pkg::S_IDLE)
    |=> st_ff.go && st_ff.pend[`WSQ_SRC_DIRECT];
  endproperty
  a_dirPending: assert property (p_dirPending) // R07
    else $error("Direct start lost while busy");
  property p_trigPend;
    spareWr && (regWrData[15:0] != 16'h0)
    |=> ((st_ff.pend[15:0] & $past(regWrData[15:0])) ==
         $past(regWrData[15:0]));
  endproperty
  a_trigPend: assert property (p_trigPend) // R01
    else $error("Trigger write not pending");
  property p_abortStop;
    abortNow |=> (st_ff.st == wsq_pkg::S_IDLE) && !seqWrEn &&
                 (!$past(qIf.popValid) || qIf.popValid);
  endproperty
  a_abortStop: assert property (p_abortStop) // R10
    else $error("Abort misbehaved");
  property p_advance;
    s_stepOn |=> (st_ff.ptr == $past(st_ff.ptr) + 9'h1)
                 ##[0:GapMax] (st_ff.st != wsq_pkg::S_GAP);
  endproperty
  a_advance: assert property (p_advance) // R17
    else $error("Pointer did not advance or gap stuck");
  property p_gapLen;
    s_stepOn |=> st_ff.gap ==
      ($past(systemClockPresent) ? StepFast : StepSlow) - 8'h1;
  endproperty
  a_gapLen: assert property (p_gapLen) // R14
    else $error("Step gap length wrong");
  property p_busy;
    (st_ff.st == wsq_pkg::S_IDLE) && qIf.popValid &&
    (qIf.popData.idx <= `WSQ_LAST_ENTRY) |=> sequencerOccupiedFlag [*3];
  endproperty
  a_busy: assert property (p_busy) // R18
    else $error("Busy dropped during a sequence");
  property p_memWindow;
    (st_ff.st != wsq_pkg::S_IDLE) |-> (st_ff.ptr <= `WSQ_LAST_ENTRY);
  endproperty
  a_memWindow: assert property (p_memWindow) // R11
    else $error("Pointer left the command window");
  property p_pathReq;
    (|pathRise) |=> (|st_ff.pend[21:20]);
  endproperty
  a_pathReq: assert property (p_pathReq) // R15
    else $error("Path enable did not request a sequence");
  property p_evtReq;
    (|autoEvent) |=> (|st_ff.pend[19:16]);
  endproperty
  a_evtReq: assert property (p_evtReq) // R16
    else $error("Event did not request a sequence");
  property p_dirIdx;
    dirWr |=> (st_ff.dirIdx == $past(regWrData[8:0]));
  endproperty
  a_dirIdx: assert property (p_dirIdx) // R12
    else $error("Direct index not stored");
endmodule

// [testbench/wsq_top_test.sv]
`timescale 1ns/1ns
`include "wsq_cfg.svh"
module wsq_top_test;
  logic         sys_clk;
  logic         rstn;
  logic         swReset;
  logic         regWrEn;
  logic         regRdEn;
  logic [15:0]  regAddr;
  logic [31:0]  regWrData;
  logic         systemClockPresent;
  logic [3:0]   autoEvent;
  logic [1:0]   outPathEnable;
  logic         regRdValid;
  logic [31:0]  regRdData;
  logic         seqWrEn;
  logic [13:0]  seqWrAddr;
  logic [15:0]  seqWrData;
  logic         sequencerOccupiedFlag;
  logic [29:0]  wrQ[$];
  logic [31:0]  rdQ[$];
  logic [13:0]  memAddr[256];
  logic [15:0]  memData[256];
  logic         memLast[256];
  logic [255:0] trgTbl;
  logic [31:0]  rngState;
  int           errTotal;
  int           checksDone;
  int           cycCnt;

  wsq_top wsq_top_i (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .swReset              (swReset),
    .regWrEn              (regWrEn),
    .regRdEn              (regRdEn),
    .regAddr              (regAddr),
    .regWrData            (regWrData),
    .systemClockPresent   (systemClockPresent),
    .autoEvent            (autoEvent),
    .outPathEnable        (outPathEnable),
    .regRdValid           (regRdValid),
    .regRdData            (regRdData),
    .seqWrEn              (seqWrEn),
    .seqWrAddr            (seqWrAddr),
    .seqWrData            (seqWrData),
    .sequencerOccupiedFlag(sequencerOccupiedFlag)
  );

  // Free-running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (wrQ.size() != 0 || rdQ.size() != 0) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, wrQ.size(), 0);
    end
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Strobes are one-cycle pulses, so a call always leaves an idle edge
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn   <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
  endtask

  // Random target and data per entry, remembered for expectations
  task automatic prog(input int i, input logic last);
    rngState   = xorshift(rngState);
    memAddr[i] = rngState[13:0];
    memData[i] = rngState[31:16];
    memLast[i] = last;
    reg_wr(`WSQ_MEM_BASE + 16'(2 * i), {memData[i], memAddr[i], 1'b0, last});
  endtask

  task automatic expect_seq(input int s);
    int i;
    i = s;
    do begin
      wrQ.push_back({memAddr[i], memData[i]});
      i++;
    end while (!memLast[i - 1] && i < 252);
  endtask

  task automatic trig(input logic [15:0] m);
    reg_wr(`WSQ_SPARE_ADDR, {16'h0000, m});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(negedge sys_clk);
    while (sequencerOccupiedFlag !== 1'b0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check(n < 2000, 32'h1);
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic wait_write();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (seqWrEn !== 1'b1 && n < 200);
    check(seqWrEn, 32'h1);
  endtask

  // Outputs are registered, so the falling edge sees them settled
  always @(negedge sys_clk) begin
    if (seqWrEn === 1'b1) begin
      if (wrQ.size() == 0) begin
        check({2'h0, seqWrAddr, seqWrData}, 32'hffffffff);
      end else begin
        check({2'h0, seqWrAddr, seqWrData}, {2'h0, wrQ.pop_front()});
      end
    end
    if (regRdValid === 1'b1) begin
      if (rdQ.size() == 0) begin
        check(regRdData, 32'hdeadbeef);
      end else begin
        check(regRdData, rdQ.pop_front());
      end
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 40000) begin
      errTotal++;
      final_report();
    end
  end

  initial begin
    rngState           = 32'h0000004c;
    trgTbl             = `WSQ_TRG_IDX_TBL;
    errTotal           = 0;
    checksDone         = 0;
    cycCnt             = 0;
    rstn               = 1'b0;
    swReset            = 1'b0;
    regWrEn            = 1'b0;
    regRdEn            = 1'b0;
    regAddr            = 16'h0000;
    regWrData          = 32'h00000000;
    systemClockPresent = 1'b1;
    autoEvent          = 4'h0;
    outPathEnable      = 2'h0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    reg_rd(`WSQ_DIRECT_ADDR, 32'h0);
    reg_rd(trgTbl[15:0], 32'h1ff);
    reg_rd(`WSQ_STATUS_ADDR, 32'h0);
    reg_rd(16'h0100, 32'h0);
    for (int i = 0; i < 3; i++) prog(i, i == 2);
    prog(10, 1'b0);
    prog(11, 1'b1);
    prog(250, 1'b0);
    prog(251, 1'b0);
    for (int i = 0; i < 4; i++) prog(32'he0 + 8 * i, 1'b1);
    reg_rd(16'h3016, {memData[11], memAddr[11], 2'b01});
    // Every trigger bit, alternating start index
    for (int k = 0; k < 16; k++) begin
      reg_wr(trgTbl[k*16 +: 16], (k % 2) ? 32'd10 : 32'd0);
      expect_seq((k % 2) ? 10 : 0);
      trig(16'(1 << k));
      wait_idle();
    end
    // Two requests at once run in turn while busy reads high
    expect_seq(0);
    expect_seq(10);
    trig(16'h8001);
    reg_rd(`WSQ_STATUS_ADDR, 32'h1);
    wait_idle();
    reg_rd(`WSQ_STATUS_ADDR, 32'h0);
    // All-ones index skips its sequence
    reg_wr(trgTbl[31:16], 32'h1ff);
    expect_seq(0);
    trig(16'h0003);
    wait_idle();
    // Abort after the first write keeps the queued request
    wrQ.push_back({memAddr[0], memData[0]});
    expect_seq(10);
    trig(16'h8001);
    wait_write();
    reg_wr(`WSQ_DIRECT_ADDR, 32'h800);
    wait_idle();
    // Direct go without enable is ignored
    reg_wr(`WSQ_DIRECT_ADDR, 32'h40a);
    wait_idle();
    reg_rd(`WSQ_DIRECT_ADDR, 32'h00a);
    // Direct run to the last entry, go clears itself
    expect_seq(250);
    reg_wr(`WSQ_DIRECT_ADDR, 32'h6fa);
    wait_idle();
    reg_rd(`WSQ_DIRECT_ADDR, 32'h2fa);
    // Direct go while a trigger sequence runs waits its turn
    expect_seq(0);
    expect_seq(10);
    trig(16'h0001);
    wait_write();
    reg_wr(`WSQ_DIRECT_ADDR, 32'h60a);
    wait_idle();
    for (int k = 0; k < 4; k++) begin
      reg_wr(`WSQ_EVT_IDX_BASE + 16'(k), (k % 2) ? 32'd10 : 32'd0);
      expect_seq((k % 2) ? 10 : 0);
      @(posedge sys_clk);
      autoEvent[k] <= 1'b1;
      @(posedge sys_clk);
      autoEvent <= 4'h0;
      wait_idle();
    end
    // Earpiece sequences sit below the headphone ones
    for (int p = 0; p < 2; p++) begin
      expect_seq(p ? 32'he0 : 32'hf0);
      @(posedge sys_clk);
      outPathEnable[p] <= 1'b1;
      wait_idle();
      expect_seq(p ? 32'he8 : 32'hf8);
      @(posedge sys_clk);
      outPathEnable[p] <= 1'b0;
      wait_idle();
    end
    @(posedge sys_clk);
    systemClockPresent <= 1'b0;
    expect_seq(0);
    trig(16'h0001);
    wait_idle();
    @(posedge sys_clk);
    systemClockPresent <= 1'b1;
    // Soft reset restores indices but keeps the memory
    @(posedge sys_clk);
    swReset <= 1'b1;
    @(posedge sys_clk);
    swReset <= 1'b0;
    reg_rd(trgTbl[15:0], 32'h1ff);
    reg_wr(trgTbl[15:0], 32'h0);
    expect_seq(0);
    trig(16'h0001);
    wait_idle();
    final_report();
  end
endmodule
